// ===== shared/adc_regs.svh
// Timing counts, edge numbers and code limits for the serial converter readout.
// Assumes the system clock runs at 25 MHz; all counts are derived from it.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// System clock period in nanoseconds.
`define MCLK_NS 40
// Longest conversion time, in nanoseconds, and its count rounded down.
`define CONV_NS 21000
`define CONV_CYC (`CONV_NS / `MCLK_NS)
// Abort window after the tenth falling edge, in nanoseconds, rounded down.
`define ABORT_NS 9000
`define ABORT_CYC (`ABORT_NS / `MCLK_NS)
// Select settle time, in nanoseconds; two cycles are spent in the synchroniser.
`define CS_FILT_NS 1425
`define CS_FILT_CYC ((`CS_FILT_NS / `MCLK_NS) - 2)
// Falling-edge numbers that steer sampling and the end of a long transfer.
`define EDGE_SAMPLE_ON 5'h03
`define EDGE_SAMPLE_OFF 5'h0A
`define EDGE_LONG_END 5'h10
// Result width, buffer depth and the two clamp codes.
`define RES_W 10
`define FIFO_DEPTH 16
`define CODE_ONES 10'h3FF
`define CODE_ZEROS 10'h000

`endif

// ===== shared/adc_pkg.sv
// Types shared by the converter readout modules.
// Assumes adc_regs.svh is on the include path.
`include "adc_regs.svh"

package adc_pkg;
  // One conversion result.
  typedef logic [`RES_W-1:0] code_t;
  // Control states, Gray coded from ST_IDLE to ST_TAIL; the return to ST_IDLE changes two bits.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_XFER = 3'h1,
    ST_CONV = 3'h3,
    ST_PUSH = 3'h2,
    ST_TAIL = 3'h6
  } state_t;
endpackage

// ===== shared/stream_if.sv
// Valid/ready word stream between the converter core and its result buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface stream_if #(parameter int W = 10);
  // Word offered by the source.
  logic valid;
  // Sink can take the word.
  logic ready;
  // The word itself.
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== design/res_fifo.sv
// Result buffer: a synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns

module res_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Filling side and draining side.
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  // Storage words.
  logic [W-1:0] mem [DEPTH];
  // Pointers carry one extra bit to tell full from empty.
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = mem[rd_ptr[AW-1:0]];

  // Write side stores a word on each accepted push.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
    end else if (fill.valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Storage has no reset; a word is only read after it was written.
  always_ff @(posedge mclk) begin
    if (fill.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  // Read side advances on each accepted pop.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr <= '0;
    end else if (drain.ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ===== design/adc_serial_core.sv
// Control and serial readout of a 10-bit successive-approximation converter.
// Assumes a host drives select and shift clock; the analog front end presents
// its level as a code plus over/under flags, synchronous to mclk.
`timescale 1ns/1ns
`include "adc_regs.svh"

module adc_serial_core (
  // System clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Serial link from the host.
  input wire logic link_clk,
  input wire logic cs_n,
  output logic sdo,
  output logic sdo_oe_n,
  // Analog front end.
  input wire adc_pkg::code_t ain_code,
  input wire logic ain_over,
  input wire logic ain_under,
  output logic sample_en,
  output logic conv_busy
);
  import adc_pkg::*;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------

  // Binary counts of falling and rising link clock edges.
  logic [1:0] fall_bin;
  logic [1:0] rise_bin;
  // Gray images of the counts, the only values that cross domains.
  logic [1:0] fall_gray;
  logic [1:0] rise_gray;
  logic [1:0] next_fall_bin;
  logic [1:0] next_rise_bin;

  assign next_fall_bin = fall_bin + 2'h1;
  assign next_rise_bin = rise_bin + 2'h1;

  // Count falling edges; one bit changes per edge in the Gray image.
  always_ff @(negedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_bin <= 2'h0;
      fall_gray <= 2'h0;
    end else begin
      fall_bin <= next_fall_bin;
      fall_gray <= next_fall_bin ^ {1'b0, next_fall_bin[1]};
    end
  end

  // Count rising edges; they mark a long transfer.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_bin <= 2'h0;
      rise_gray <= 2'h0;
    end else begin
      rise_bin <= next_rise_bin;
      rise_gray <= next_rise_bin ^ {1'b0, next_rise_bin[1]};
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the system clock domain
  // ----------------------------------------------------------------

  // Two-stage synchronisers; the first stage feeds only the second.
  logic [1:0] fall_meta;
  logic [1:0] fall_sync;
  logic [1:0] fall_prev;
  logic [1:0] rise_meta;
  logic [1:0] rise_sync;
  logic [1:0] rise_prev;
  logic cs_meta;
  logic cs_sync;
  // One-cycle events for each link clock edge seen.
  logic fall_evt;
  logic rise_evt;

  // Synchronise the edge counts and keep the last value for comparison.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fall_meta <= 2'h0;
      fall_sync <= 2'h0;
      fall_prev <= 2'h0;
      rise_meta <= 2'h0;
      rise_sync <= 2'h0;
      rise_prev <= 2'h0;
    end else begin
      fall_meta <= fall_gray;
      fall_sync <= fall_meta;
      fall_prev <= fall_sync;
      rise_meta <= rise_gray;
      rise_sync <= rise_meta;
      rise_prev <= rise_sync;
    end
  end

  // Synchronise the select pin; it idles high (deselected).
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
    end
  end

  // A change of the Gray count means one new edge.
  assign fall_evt = (fall_sync != fall_prev);
  assign rise_evt = (rise_sync != rise_prev);

  // ----------------------------------------------------------------
  // Select noise filter
  // ----------------------------------------------------------------

  // Accepted select level and the time the pin has differed from it.
  logic cs_filt;
  logic [5:0] filt_cnt;
  logic filt_done;
  logic cs_ok;
  logic cs_accept_low;

  assign filt_done = (filt_cnt == 6'(`CS_FILT_CYC - 1));
  assign cs_ok = !cs_filt;
  // Fires in the cycle a low select is first accepted.
  assign cs_accept_low = cs_filt && !cs_sync && filt_done;

  // A new level is accepted only after it has stood the full settle time.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_filt <= 1'b1;
      filt_cnt <= 6'h00;
    end else if (cs_sync == cs_filt) begin
      // Glitch or steady level: restart the settle count.
      filt_cnt <= 6'h00;
    end else if (filt_done) begin
      // Level held long enough: accept it, in either direction.
      cs_filt <= cs_sync;
      filt_cnt <= 6'h00;
    end else begin
      filt_cnt <= filt_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------

  // Finished results go into the buffer and leave it at the next load.
  stream_if #(.W(`RES_W)) res_in ();
  stream_if #(.W(`RES_W)) res_out ();

  res_fifo #(
    .W(`RES_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_res_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .fill(res_in.snk),
    .drain(res_out.src)
  );

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------

  // Current state, shift-clock falls seen and long-transfer flag.
  state_t state;
  logic [4:0] bit_cnt;
  logic long_xfer;
  // Conversion timer in system clock cycles.
  logic [9:0] conv_tmr;
  logic conv_end;
  logic abort_ok;
  // A counted falling edge while the select is accepted low.
  logic fall_ok;
  // Transfer tail finished, so the next word may be loaded.
  logic tail_done;
  // Held sample, word being converted and last word presented.
  code_t samp_word;
  code_t last_word;
  // Output shift register; its top bit drives the pin.
  code_t shift;

  assign conv_end = (conv_tmr == 10'(`CONV_CYC - 1));
  assign abort_ok = (conv_tmr < 10'(`ABORT_CYC));
  // Edges are ignored until select has settled low.
  assign fall_ok = fall_evt && cs_ok && (state != ST_IDLE);
  assign tail_done = !long_xfer || (bit_cnt == `EDGE_LONG_END) || !cs_ok;

  assign res_in.valid = (state == ST_PUSH);
  assign res_in.data = samp_word;
  assign res_out.ready = (state == ST_TAIL) && tail_done;

  // State sequencing: transfer, conversion, buffering and tail.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          // Held-low select starts the next transfer at once.
          if (cs_ok) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (!cs_ok) begin
            // Select rose early: the partial transfer is dropped.
            state <= ST_IDLE;
          end else if (fall_ok && (bit_cnt == `EDGE_SAMPLE_OFF - 5'h01)) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (cs_accept_low && abort_ok) begin
            // New select fall inside the window abandons the conversion.
            state <= ST_IDLE;
          end else if (conv_end) begin
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          // Wait here while the buffer is full.
          if (res_in.ready) begin
            state <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          // Leave once the tail is over and a word is loaded.
          if (tail_done && res_out.valid) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Count accepted falling edges, saturating at the long length.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 5'h00;
    end else if (state == ST_IDLE) begin
      bit_cnt <= 5'h00;
    end else if (fall_ok && (bit_cnt != `EDGE_LONG_END)) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // A rising edge after the tenth fall marks a long transfer.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      long_xfer <= 1'b0;
    end else if (state == ST_IDLE) begin
      long_xfer <= 1'b0;
    end else if (rise_evt && cs_ok && (bit_cnt >= `EDGE_SAMPLE_OFF)) begin
      long_xfer <= 1'b1;
    end
  end

  // Conversion timer runs only while converting.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_tmr <= 10'h000;
    end else if (state == ST_CONV) begin
      conv_tmr <= conv_tmr + 10'h001;
    end else begin
      conv_tmr <= 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // Sampling and conversion result
  // ----------------------------------------------------------------

  // Sampling window opens at the third fall and closes at the tenth.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sample_en <= 1'b0;
    end else if (state != ST_XFER) begin
      sample_en <= 1'b0;
    end else if (fall_ok && (bit_cnt == `EDGE_SAMPLE_ON - 5'h01)) begin
      sample_en <= 1'b1;
    end else if (fall_ok && (bit_cnt == `EDGE_SAMPLE_OFF - 5'h01)) begin
      sample_en <= 1'b0;
    end
  end

  // Hold the sample at the tenth fall, clamping out-of-range inputs.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      samp_word <= `CODE_ZEROS;
    end else if (state == ST_XFER && fall_ok && (bit_cnt == `EDGE_SAMPLE_OFF - 5'h01)) begin
      if (ain_over) begin
        samp_word <= `CODE_ONES;
      end else if (ain_under) begin
        samp_word <= `CODE_ZEROS;
      end else begin
        samp_word <= ain_code;
      end
    end
  end

  // Busy from the tenth fall until the result is buffered.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= (state == ST_CONV) || (state == ST_PUSH);
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------

  // Shift register: loaded with a result, moved on each accepted fall.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift <= `CODE_ZEROS;
      last_word <= `CODE_ZEROS;
    end else if (res_out.ready && res_out.valid) begin
      // New result presented MSB first, straight binary.
      shift <= res_out.data;
      last_word <= res_out.data;
    end else if ((state == ST_XFER && !cs_ok) ||
                 (state == ST_CONV && cs_accept_low && abort_ok)) begin
      // Dropped transfer or abort: present the same word again.
      shift <= last_word;
    end else if (fall_ok) begin
      // Zeros fill in, so bits past the tenth read low.
      shift <= {shift[`RES_W-2:0], 1'b0};
    end
  end

  assign sdo = shift[`RES_W-1];

  // Output enable follows the synchronised pin, not the filter.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= cs_sync;
    end
  end
endmodule

// ===== verif/adc_link_monitor.sv
// Checker for the serial converter readout, bound to the top module.
// Assumes it watches only mclk-domain relations; link timing is judged by the host model.
`timescale 1ns/1ns

module adc_link_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Link pins.
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  // Converter status.
  input wire logic sample_en,
  input wire logic conv_busy
);
  // --------------------
  // Helper counters
  // --------------------
  logic [7:0] lo_cnt; // Cycles select has been low, saturating.
  logic [7:0] hi_cnt; // Cycles select has been high, saturating.
  logic [7:0] samp_cnt; // Cycles of the current sampling window.
  logic [9:0] busy_cnt; // Cycles of the current conversion.

  // Each counter restarts when the level it times goes away.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
      samp_cnt <= 8'h00;
      busy_cnt <= 10'h000;
    end else begin
      lo_cnt <= cs_n ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
      hi_cnt <= !cs_n ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
      samp_cnt <= sample_en ? samp_cnt + 8'h01 : 8'h00;
      busy_cnt <= conv_busy ? busy_cnt + 10'h001 : 10'h000;
    end
  end

  // --------------------
  // Assertions
  // --------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  oe_on_a: assert property (!cs_n [*4] |-> !sdo_oe_n)
    else $error("Output not enabled after select fell.");
  oe_off_a: assert property (cs_n [*4] |-> sdo_oe_n)
    else $error("Output still driven after select rose.");
  conv_start_a: assert property ($rose(conv_busy) |-> $past(sample_en, 2) && !$past(sample_en) && !sdo)
    else $error("Conversion start not tied to window end.");
  samp_len_a: assert property ($fell(sample_en) |-> samp_cnt >= 8'h1B && samp_cnt <= 8'h1D)
    else $error("Sampling window not seven link periods.");
  samp_gate_a: assert property ($rose(sample_en) |-> lo_cnt >= 8'h23)
    else $error("Sampling began before select settled.");
  clk_off_a: assert property (hi_cnt >= 8'h25 |-> !$rose(sample_en) && !$rose(conv_busy))
    else $error("Link clock obeyed while deselected.");
  busy_len_a: assert property (conv_busy |-> busy_cnt <= 10'h20F)
    else $error("Conversion ran too long.");
  abort_a: assert property ($fell(conv_busy) && busy_cnt < 10'h1F4 |-> !cs_n && busy_cnt < 10'hE4)
    else $error("Conversion cut short without a timely abort.");
  excl_a: assert property (sample_en |-> !conv_busy)
    else $error("Sampling and converting at once.");

  // Main scenarios seen at least once.
  cover property ($rose(conv_busy));
  cover property ($fell(conv_busy) && busy_cnt < 10'h1F4);
  cover property ($fell(sdo_oe_n));
endmodule

bind adc_serial_core adc_link_monitor adc_link_monitor_i (.mclk(mclk), .arst_n(arst_n),
  .cs_n(cs_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sample_en(sample_en), .conv_busy(conv_busy));

// ===== verif/host_link_model.sv
// Host serial port acting as link master: drives select and shift clock, reads the pin.
// Assumes the bench calls its tasks one at a time; the clock idles low between frames.
`timescale 1ns/1ns

module host_link_model (
  // Link pins toward the device.
  output logic cs_n,
  output logic link_clk,
  // Serial data and its enable from the device.
  input wire logic sdo,
  input wire logic sdo_oe_n,
  // Received word and a toggle per completed word.
  output logic [15:0] rx_word,
  output logic rx_tgl
);
  logic pin; // Level on the wire; floats when the device lets go.

  assign pin = sdo_oe_n ? 1'bz : sdo;

  // Idle link: deselected, clock low.
  initial begin
    cs_n = 1'b1;
    link_clk = 1'b0;
    rx_word = 16'h0000;
    rx_tgl = 1'b0;
  end

  // Sets select and holds it; callers other than the 600 ns noise pulse and the 0 ns early-clock step of mode 2 lower it for at least the setup time.
  task automatic cs_drive(input logic v, input int hold_ns);
    cs_n = v;
    #(hold_ns);
  endtask

  // Gives n clocks of 160 ns and samples each bit just before the next rise.
  task automatic shift(input int n, input int pause_ns, input bit rec);
    logic [15:0] w;
    w = 16'h0000;
    for (int k = 1; k <= n; k++) begin
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      #79;
      w[16-k] = pin;
      #1;
      if (k == 11) #(pause_ns);
    end
    #200;
    if (rec) begin
      rx_word = w;
      #1;
      rx_tgl = ~rx_tgl;
    end
  endtask
endmodule

// ===== verif/adc_serial_core_tb_top.sv
// Self-checking bench for the serial converter readout with a host model on the link.
// Assumes the design package, header and interface are compiled first.
`timescale 1ns/1ns

module adc_serial_core_tb_top;
  import adc_pkg::*;
  // --------------------
  // Signals and bookkeeping
  // --------------------
  logic mclk;
  logic arst_n;
  logic link_clk;
  logic cs_n;
  logic sdo;
  logic sdo_oe_n;
  code_t ain_code;
  logic ain_over;
  logic ain_under;
  logic sample_en;
  logic conv_busy;
  logic [15:0] rx_word;
  logic rx_tgl;
  logic [15:0] exp_q[$]; // Words the host should read, oldest first.
  code_t cur; // Word the device holds for the next read.
  logic [31:0] seed;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  adc_serial_core adc_serial_core_i (.mclk(mclk), .arst_n(arst_n), .link_clk(link_clk),
    .cs_n(cs_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .ain_code(ain_code),
    .ain_over(ain_over), .ain_under(ain_under), .sample_en(sample_en),
    .conv_busy(conv_busy));
  host_link_model host_link_model_i (.cs_n(cs_n), .link_clk(link_clk), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .rx_word(rx_word), .rx_tgl(rx_tgl));

  // 25 MHz system clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // --------------------
  // Helpers
  // --------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // One transfer. Mode 0 framed, 1 select held low, 2 framed after noise and early clocks.
  task automatic run(input int n, input int mode, input logic ov, input logic un,
                     input int pause_ns, input bit ab);
    seed = xorshift(seed);
    @(posedge mclk);
    ain_code <= seed[9:0];
    ain_over <= ov;
    ain_under <= un;
    exp_q.push_back({cur, 6'h00});
    #(seed[14:10] + 1); // Random phase of the link against mclk.
    if (mode == 2) begin
      host_link_model_i.cs_drive(1'b0, 600);
      host_link_model_i.cs_drive(1'b1, 1600);
      host_link_model_i.shift(3, 0, 1'b0);
      host_link_model_i.cs_drive(1'b0, 0);
      host_link_model_i.shift(2, 0, 1'b0);
    end
    if (mode != 1) host_link_model_i.cs_drive(1'b0, 1600);
    host_link_model_i.shift(n, pause_ns, 1'b1);
    if (mode != 1) host_link_model_i.cs_drive(1'b1, 1600);
    if (ab) begin
      host_link_model_i.cs_drive(1'b0, 2000);
      chk_bit(conv_busy, 1'b0);
      host_link_model_i.cs_drive(1'b1, 1600);
    end else begin
      cur = ov ? 10'h3FF : (un ? 10'h000 : seed[9:0]);
    end
    for (int i = 0; i < 700 && conv_busy !== 1'b0; i++) @(posedge mclk);
    chk_bit(conv_busy, 1'b0);
    if (mode != 1) chk_bit(sdo_oe_n, 1'b1);
    $display("Test done: %0d clocks, mode %0d.", n, mode);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d.", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watcher: each word the host reads is matched with the oldest note.
  always @(rx_tgl) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) chk_bit(1'b0, 1'b1);
      else chk_word(rx_word, exp_q.pop_front());
    end
  end

  // Hang guard, well above the planned run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    arst_n = 1'b0;
    ain_code = 10'h000;
    ain_over = 1'b0;
    ain_under = 1'b0;
    seed = 32'hDE73;
    cur = 10'h000;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 3; i++) run(10, 0, 1'b0, 1'b0, 0, 1'b0);
    run(10, 0, 1'b1, 1'b0, 0, 1'b0);
    run(10, 0, 1'b0, 1'b1, 0, 1'b0);
    run(10, 0, 1'b1, 1'b1, 0, 1'b0);
    host_link_model_i.cs_drive(1'b0, 1600);
    run(10, 1, 1'b0, 1'b0, 0, 1'b0);
    run(10, 1, 1'b0, 1'b0, 0, 1'b0);
    run(16, 1, 1'b0, 1'b0, 0, 1'b0);
    run(16, 1, 1'b0, 1'b0, 25000, 1'b0);
    host_link_model_i.cs_drive(1'b1, 1600);
    run(12, 0, 1'b0, 1'b0, 0, 1'b0);
    run(16, 0, 1'b0, 1'b0, 25000, 1'b0);
    run(10, 0, 1'b0, 1'b0, 0, 1'b1);
    run(10, 2, 1'b0, 1'b0, 0, 1'b0);
    run(10, 0, 1'b0, 1'b0, 0, 1'b0);
    repeat (20) @(posedge mclk);
    chk_bit(exp_q.size() == 0, 1'b1);
    print_verdict();
  end
endmodule
